// ==== rtl/stg_pkg.sv ====
// Constants, register map and types of the sweep trigger gate sequencer
package stg_pkg;
  // ****************************************************************
  // Timebase
  // ****************************************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_US = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int TICKS_PER_S = 1_000_000 / TICK_US;
  localparam int TICKS_PER_MS = TICKS_PER_S / 1000;
  localparam logic [16:0] TB_TICKS_PER_S = 17'(TICKS_PER_S);
  // ****************************************************************
  // Durations and limits, given in s, us, ms and MHz, with the derived limits counted in timebase ticks
  // ****************************************************************
  localparam int DLY_W = 24;
  localparam int SWP_W = 27;
  localparam int TRIG_DELAY_MAX_S = 100;
  localparam logic [DLY_W-1:0] TRIG_DELAY_MAX = DLY_W'(TRIG_DELAY_MAX_S * TICKS_PER_S);
  localparam int SWEEP_MAX_S = 1000;
  localparam logic [SWP_W-1:0] SWEEP_MAX = SWP_W'(SWEEP_MAX_S * TICKS_PER_S);
  localparam int SWEEP_MIN_ZS_US = 200;
  localparam logic [SWP_W-1:0] SWEEP_MIN_ZS = SWP_W'(SWEEP_MIN_ZS_US / TICK_US);
  localparam int COUPLE_MS = 20;
  localparam int COUPLE_MHZ = 600;
  // Floor per MHz of span is COUPLE_NUM / COUPLE_DEN ticks
  localparam logic [39:0] COUPLE_NUM = 40'(COUPLE_MS * TICKS_PER_MS);
  localparam logic [39:0] COUPLE_DEN = 40'(COUPLE_MHZ);
  // ****************************************************************
  // Register map (byte offsets)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TRIG_DELAY = 8'h04;
  localparam logic [7:0] OFS_GATE_DELAY = 8'h08;
  localparam logic [7:0] OFS_GATE_LENGTH = 8'h0c;
  localparam logic [7:0] OFS_USER_SWEEP = 8'h10;
  localparam logic [7:0] OFS_SPAN = 8'h14;
  localparam logic [7:0] OFS_VIDEO = 8'h18;
  localparam logic [7:0] OFS_INT_RATE = 8'h1c;
  localparam logic [7:0] OFS_AVG_COUNT = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_SWEEP_EFF = 8'h28;
  // Control fields
  localparam int CTRL_SINGLE = 0;
  localparam int CTRL_SRC_LO = 1;
  localparam int CTRL_FALLING = 3;
  localparam int CTRL_GATE = 4;
  localparam int CTRL_AUTO = 5;
  localparam int CTRL_FFT = 6;
  localparam int CTRL_GATE_EDIT = 7;
  localparam int CTRL_START = 31;
  localparam logic [7:0] CTRL_RST = 8'h20;
  localparam logic [9:0] AVG_RST = 10'h001;
  localparam logic [SWP_W-1:0] USER_SWEEP_RST = SWP_W'(SWEEP_MIN_ZS);
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    SRC_FREE = 2'b00,
    SRC_VIDEO = 2'b01,
    SRC_EXT = 2'b10,
    SRC_INTL = 2'b11
  } stg_src_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARM = 3'b001,
    ST_TDELAY = 3'b010,
    ST_SWEEP = 3'b011,
    ST_GATE_WAIT = 3'b100,
    ST_GATE_DLY = 3'b101,
    ST_GATE_OPEN = 3'b110
  } stg_state_e;
endpackage : stg_pkg

// ==== rtl/stg_downcounter.sv ====
// Loadable down-counter stepping on the common timebase tick
module stg_downcounter (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic load_i,
  input wire logic [stg_pkg::SWP_W-1:0] load_val_i,
  input wire logic run_i,
  output logic [stg_pkg::SWP_W-1:0] count_o,
  output logic zero_o
);
  import stg_pkg::*;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_o <= '0;
    end else if (load_i) begin
      count_o <= load_val_i;
    end else if (run_i && count_o != '0) begin
      count_o <= count_o - SWP_W'(1);
    end
  end

  assign zero_o = (count_o == '0);
endmodule : stg_downcounter

// ==== rtl/stg_sequencer.sv ====
// Sweep trigger gate sequencer with classic Wishbone register slave
// Summary of operation
// [R1] Continuous mode restarts the sweep after each completion and flags a trace update.
// [R2] Single mode runs average-count sweeps, halts, waits for a new start.
// [R3] Free run starts the next sweep at once when one finishes.
// [R4] Video trigger fires on level rising above threshold, only at zero span.
// [R5] Threshold is percent of reference level; 100 is reference, 50 mid-scale.
// [R6] External trigger starts on selected rising or falling input edge.
// [R7] Gated: measuring starts after gate activation plus gate delay.
// [R8] Gated: measuring pauses after gate length, resumes same sweep next gate.
// [R9] Gating only with external (or internal timebase) source, any span.
// [R10] Gating refused while forced transform sweep type is selected.
// [R11] Internal periodic timebase in hertz starts sweeps, usable with gating.
// [R12] Video and external starts delayed by zero to 100 s.
// [R13] Trigger delay quantised by range: 10 us steps up to 1 s steps.
// [R14] Coupled sweep time is shortest valid, at least 20 ms per 600 MHz.
// [R15] Zero span sweep time limited to 1000 s, axis from 0 s.
// [R16] Manual sweep time with coupling off raises the override indicator.
// [R17] Gate editing forces zero span; leaving restores stored span.
// [R18] External input passes two synchroniser flops before any use.
// [R19] Delays, gate and sweep times are tick down-counters loaded per phase.
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
module stg_sequencer (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_trig_i,
  input wire logic [6:0] video_level_i,
  output logic sweeping_o,
  output logic measuring_o,
  output logic sweep_done_o,
  output logic halted_o,
  output logic zero_span_o,
  output logic [15:0] span_mhz_o,
  output logic sweep_duration_indicator_o,
  output logic gate_refused_o
);
  import stg_pkg::*;

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0] ctrl;
  logic [DLY_W-1:0] trig_delay;
  logic [SWP_W-1:0] gate_delay;
  logic [SWP_W-1:0] gate_length;
  logic [SWP_W-1:0] user_sweep_duration;
  logic [15:0] span_mhz;
  logic [6:0] video_thr;
  logic [2:0] resolution_bandwidth;
  logic [15:0] int_rate_hz;
  logic [9:0] avg_count;
  logic start_pend;
  logic [9:0] sweeps;
  stg_state_e state;
  stg_state_e next_state;
  logic [SWP_W-1:0] sweep_eff;
  logic [31:0] rd_data;
  logic [31:0] wr_word;
  logic wb_req;
  logic wb_wr;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] dat,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // Round down to the step of the delay's decade
  function automatic logic [DLY_W-1:0] quantise(input logic [31:0] d);
    logic [31:0] c;
    logic [31:0] step;
    c = (d > 32'(TRIG_DELAY_MAX)) ? 32'(TRIG_DELAY_MAX) : d;
    if (c < 32'h0000_0064) begin
      step = 32'h0000_0001;
    end else if (c < 32'h0000_03e8) begin
      step = 32'h0000_000a;
    end else if (c < 32'h0000_2710) begin
      step = 32'h0000_0064;
    end else if (c < 32'h0001_86a0) begin
      step = 32'h0000_03e8;
    end else if (c < 32'h000f_4240) begin
      step = 32'h0000_2710;
    end else begin
      step = 32'h0001_86a0;
    end
    return DLY_W'(c - (c % step));
  endfunction : quantise

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;
  assign wr_word = merge_bytes(rd_data, wb_dat_i, wb_sel_i);

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl <= CTRL_RST;
      trig_delay <= '0;
      gate_delay <= '0;
      gate_length <= '0;
      user_sweep_duration <= USER_SWEEP_RST;
      span_mhz <= '0;
      video_thr <= '0;
      resolution_bandwidth <= '0;
      int_rate_hz <= '0;
      avg_count <= AVG_RST;
    end else if (wb_wr) begin
      case (wb_adr_i)
        OFS_CTRL: ctrl <= wr_word[7:0];
        OFS_TRIG_DELAY: trig_delay <= quantise(32'(wr_word[DLY_W-1:0])); // [R12] [R13]
        OFS_GATE_DELAY: gate_delay <= wr_word[SWP_W-1:0];
        OFS_GATE_LENGTH: gate_length <= wr_word[SWP_W-1:0];
        OFS_USER_SWEEP: user_sweep_duration <= wr_word[SWP_W-1:0];
        OFS_SPAN: span_mhz <= wr_word[15:0];
        OFS_VIDEO: begin
          video_thr <= wr_word[6:0]; // [R5]
          resolution_bandwidth <= wr_word[10:8];
        end
        OFS_INT_RATE: int_rate_hz <= wr_word[15:0];
        OFS_AVG_COUNT: avg_count <= wr_word[9:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    case (wb_adr_i)
      OFS_CTRL: rd_data = {24'h000000, ctrl};
      OFS_TRIG_DELAY: rd_data = 32'(trig_delay);
      OFS_GATE_DELAY: rd_data = 32'(gate_delay);
      OFS_GATE_LENGTH: rd_data = 32'(gate_length);
      OFS_USER_SWEEP: rd_data = 32'(user_sweep_duration);
      OFS_SPAN: rd_data = {16'h0000, span_mhz};
      OFS_VIDEO: rd_data = {21'h000000, resolution_bandwidth, 1'b0, video_thr};
      OFS_INT_RATE: rd_data = {16'h0000, int_rate_hz};
      OFS_AVG_COUNT: rd_data = {22'h000000, avg_count};
      OFS_STATUS: rd_data = {12'h000, sweeps, 2'h0, gate_refused_o, halted_o, measuring_o, start_pend,
                             1'b0, state};
      OFS_SWEEP_EFF: rd_data = 32'(sweep_eff);
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Configuration decode
  // ****************************************************************
  logic single_mode;
  stg_src_e src;
  logic gate_on;
  logic eff_zero;
  assign single_mode = ctrl[CTRL_SINGLE];
  assign src = stg_src_e'(ctrl[CTRL_SRC_LO +: 2]);
  assign eff_zero = ctrl[CTRL_GATE_EDIT] || (span_mhz == 16'h0000); // [R17]
  assign gate_on = ctrl[CTRL_GATE] && !ctrl[CTRL_FFT] && (src == SRC_EXT || src == SRC_INTL); // [R9] [R10]

  // Sweep duration: coupled floor from span and filter, or user value
  logic [39:0] couple_wide;
  logic [SWP_W-1:0] coupled_sweep_duration;
  assign couple_wide = ((40'(span_mhz) * COUPLE_NUM + COUPLE_DEN - 40'h1) / COUPLE_DEN)
                       << (2 * resolution_bandwidth); // [R14]
  assign coupled_sweep_duration = (couple_wide > 40'(SWEEP_MAX)) ? SWEEP_MAX :
                                  (couple_wide == 40'h0) ? SWP_W'(1) : couple_wide[SWP_W-1:0];

  always_comb begin
    if (eff_zero) begin
      if (!ctrl[CTRL_AUTO] && user_sweep_duration > SWEEP_MIN_ZS) begin
        sweep_eff = (user_sweep_duration > SWEEP_MAX) ? SWEEP_MAX : user_sweep_duration; // [R15]
      end else begin
        sweep_eff = SWEEP_MIN_ZS;
      end
    end else if (ctrl[CTRL_AUTO]) begin
      sweep_eff = coupled_sweep_duration;
    end else begin
      sweep_eff = (user_sweep_duration > SWEEP_MAX) ? SWEEP_MAX :
                  (user_sweep_duration == '0) ? SWP_W'(1) : user_sweep_duration;
    end
  end

  // ****************************************************************
  // Timebase tick, input synchroniser, internal rate generator
  // ****************************************************************
  logic [6:0] tick_cnt;
  logic tick;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == 7'(TICK_CYCLES - 1)); // [R19]
      tick_cnt <= (tick_cnt == 7'(TICK_CYCLES - 1)) ? 7'h00 : tick_cnt + 7'h01;
    end
  end

  logic ext_meta;
  logic ext_sync;
  logic ext_act_d;
  logic ext_act;
  logic ext_edge;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_act_d <= 1'b0;
    end else begin
      ext_meta <= ext_trig_i; // [R18]
      ext_sync <= ext_meta; // [R18]
      ext_act_d <= ext_act;
    end
  end
  assign ext_act = ext_sync ^ ctrl[CTRL_FALLING];
  assign ext_edge = ext_act && !ext_act_d; // [R6]

  logic [16:0] phase_acc;
  logic intl_evt;
  logic [16:0] phase_sum;
  assign phase_sum = phase_acc + 17'(int_rate_hz);
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_acc <= '0;
      intl_evt <= 1'b0;
    end else begin
      intl_evt <= tick && (phase_sum >= TB_TICKS_PER_S); // [R11]
      if (tick) begin
        phase_acc <= (phase_sum >= TB_TICKS_PER_S) ? phase_sum - TB_TICKS_PER_S : phase_sum;
      end
    end
  end

  logic [6:0] video_d;
  logic vid_rise;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      video_d <= '0;
    end else begin
      video_d <= video_level_i;
    end
  end
  assign vid_rise = (video_level_i > video_thr) && (video_d <= video_thr) && eff_zero; // [R4]

  // ****************************************************************
  // Phase counters: trigger delay, gate delay, gate length, sweep
  // ****************************************************************
  logic [3:0] ld;
  logic [3:0] run;
  logic [3:0] zero;
  logic [SWP_W-1:0] ld_val [4];
  assign ld_val[0] = SWP_W'(trig_delay);
  assign ld_val[1] = gate_delay;
  assign ld_val[2] = gate_length;
  assign ld_val[3] = sweep_eff;
  assign run[0] = tick && (state == ST_TDELAY);
  assign run[1] = tick && (state == ST_GATE_DLY);
  assign run[2] = tick && (state == ST_GATE_OPEN);
  assign run[3] = tick && (state == ST_SWEEP || state == ST_GATE_OPEN); // [R8]

  for (genvar i = 0; i < 4; i++) begin : g_cnt
    stg_downcounter u_cnt (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .load_i(ld[i]),
      .load_val_i(ld_val[i]),
      .run_i(run[i]),
      .count_o(),
      .zero_o(zero[i])
    );
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  logic done_now;
  logic last_single;
  logic start_take;
  assign last_single = single_mode && (sweeps + 10'h001 >= avg_count);
  assign start_take = (state == ST_IDLE) && (next_state == ST_ARM);

  always_comb begin
    next_state = state;
    ld = 4'h0;
    done_now = 1'b0;
    case (state)
      ST_IDLE: begin
        if (!single_mode || start_pend) begin // [R2]
          next_state = ST_ARM;
        end
      end
      ST_ARM: begin
        if (gate_on) begin
          next_state = ST_GATE_WAIT;
          ld[3] = 1'b1;
        end else if (src == SRC_FREE || (src == SRC_INTL && intl_evt)) begin // [R3] [R11]
          next_state = ST_SWEEP;
          ld[3] = 1'b1;
        end else if ((src == SRC_EXT && ext_edge) || (src == SRC_VIDEO && vid_rise)) begin // [R4] [R6]
          next_state = ST_TDELAY;
          ld[0] = 1'b1;
        end
      end
      ST_TDELAY: begin
        if (zero[0]) begin // [R12]
          next_state = ST_SWEEP;
          ld[3] = 1'b1;
        end
      end
      ST_SWEEP: begin
        if (zero[3]) begin
          done_now = 1'b1;
          next_state = last_single ? ST_IDLE : ST_ARM; // [R1] [R2]
        end
      end
      ST_GATE_WAIT: begin
        if ((src == SRC_EXT) ? ext_edge : intl_evt) begin // [R7]
          next_state = ST_GATE_DLY;
          ld[1] = 1'b1;
        end
      end
      ST_GATE_DLY: begin
        if (zero[1]) begin // [R7]
          next_state = ST_GATE_OPEN;
          ld[2] = 1'b1;
        end
      end
      ST_GATE_OPEN: begin
        if (zero[3]) begin
          done_now = 1'b1;
          next_state = last_single ? ST_IDLE : ST_ARM;
        end else if (zero[2]) begin
          next_state = ST_GATE_WAIT; // [R8]
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // A start written while one is consumed stays pending
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      start_pend <= 1'b0;
      sweeps <= '0;
    end else begin
      start_pend <= (wb_wr && wb_adr_i == OFS_CTRL && wb_sel_i[3] && wb_dat_i[CTRL_START]) ||
                    (start_pend && !start_take);
      if (start_take) begin
        sweeps <= '0;
      end else if (done_now) begin
        sweeps <= sweeps + 10'h001;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sweeping_o <= 1'b0;
      measuring_o <= 1'b0;
      sweep_done_o <= 1'b0;
      halted_o <= 1'b0;
      zero_span_o <= 1'b0;
      span_mhz_o <= '0;
      sweep_duration_indicator_o <= 1'b0;
      gate_refused_o <= 1'b0;
    end else begin
      sweeping_o <= (next_state != ST_IDLE);
      measuring_o <= (next_state == ST_SWEEP || next_state == ST_GATE_OPEN);
      sweep_done_o <= done_now; // [R1]
      halted_o <= (next_state == ST_IDLE) && single_mode;
      zero_span_o <= eff_zero; // [R17]
      span_mhz_o <= ctrl[CTRL_GATE_EDIT] ? 16'h0000 : span_mhz; // [R17]
      sweep_duration_indicator_o <= !ctrl[CTRL_AUTO]; // [R16]
      gate_refused_o <= ctrl[CTRL_GATE] && !gate_on; // [R10]
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_free_restart: assert property ((state == ST_SWEEP) && zero[3] && !single_mode && src == SRC_FREE && !gate_on // [R1] [R3]
    |=> (state == ST_ARM) ##1 (state == ST_SWEEP)) else $error("free run did not restart");
  a_single_halt: assert property ((state == ST_SWEEP) && zero[3] && last_single // [R2]
    |=> halted_o && (state == ST_IDLE)) else $error("single sweep did not halt");
  a_video_span: assert property ((state == ST_ARM) && src == SRC_VIDEO && !eff_zero // [R4]
    |=> state == ST_ARM) else $error("video trigger outside zero span");
  a_ext_start: assert property ((state == ST_ARM) && src == SRC_EXT && !gate_on && ext_edge // [R6]
    |=> state == ST_TDELAY) else $error("external edge missed");
  a_gate_entry: assert property ($rose(state == ST_GATE_OPEN) // [R7]
    |-> $past(state) == ST_GATE_DLY && $past(zero[1])) else $error("gate opened early");
  a_gate_pause: assert property ((state == ST_GATE_OPEN) && zero[2] && !zero[3] // [R8]
    |=> state == ST_GATE_WAIT ##1 !measuring_o) else $error("gate did not pause");
  a_fft_refuse: assert property (ctrl[CTRL_FFT] |-> !gate_on) else $error("gating with forced transform"); // [R10]
  a_delay_range: assert property (trig_delay <= TRIG_DELAY_MAX) else $error("trigger delay beyond range"); // [R12]
  a_zs_limits: assert property (eff_zero |-> sweep_eff >= SWEEP_MIN_ZS && sweep_eff <= SWEEP_MAX) // [R15]
    else $error("zero span sweep time out of range");
  a_coupled_floor: assert property (ctrl[CTRL_AUTO] && !eff_zero // [R14]
    |-> 40'(sweep_eff) * COUPLE_DEN >= 40'(span_mhz) * COUPLE_NUM || sweep_eff == SWEEP_MAX)
    else $error("coupled sweep time below floor");
  a_override_ind: assert property ($changed(ctrl[CTRL_AUTO]) // [R16]
    |=> sweep_duration_indicator_o == !$past(ctrl[CTRL_AUTO])) else $error("override indicator wrong");
  a_edit_span: assert property (ctrl[CTRL_GATE_EDIT] |=> zero_span_o && span_mhz_o == 16'h0000) // [R17]
    else $error("gate edit did not force zero span");
  a_tick_gap: assert property (tick |=> !tick [*8]) else $error("timebase tick too frequent"); // [R19]
endmodule : stg_sequencer

// ==== bench/stg_trig_src.sv ====
// External trigger and gate source model driving the sequencer's trigger pin
module stg_trig_src (
  input wire logic core_clk_i,
  input wire logic fire_i,
  input wire logic fall_i,
  input wire logic [15:0] width_i,
  output logic ext_trig_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] left = 16'h0;
  // Active pulse of width_i cycles per request, idle level set by fall_i
  always_ff @(posedge core_clk_i) begin
    if (fire_i) begin
      left <= width_i;
    end else if (left != 16'h0) begin
      left <= left - 16'h1;
    end
  end
  assign ext_trig_o = (left != 16'h0) ^ fall_i;
endmodule : stg_trig_src

// ==== bench/stg_sequencer_tb.sv ====
// Self-checking bench of the sweep trigger gate sequencer
module stg_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import stg_pkg::*;
  // ****************************************************************
  // Signals and design
  // ****************************************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic fire = 1'b0;
  logic fall = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [6:0] vid = 7'h28;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [15:0] span;
  logic ack, ext, swp, meas, done, halted, zs, sdi, refused;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  int k;
  logic [31:0] dq [8][2] = '{'{32'h63, 32'h63}, '{32'h7b, 32'h78}, '{32'h4d2, 32'h4b0}, '{32'h3039, 32'h2ee0},
    '{32'h1e240, 32'h1d4c0}, '{32'h12d687, 32'h124f80}, '{32'h98967f, 32'h970fe0}, '{32'hf42400, 32'h989680}};
  always #50 clk = ~clk;
  stg_sequencer u_dut (.core_clk_i(clk), .reset_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_trig_i(ext),
    .video_level_i(vid), .sweeping_o(swp), .measuring_o(meas), .sweep_done_o(done), .halted_o(halted),
    .zero_span_o(zs), .span_mhz_o(span), .sweep_duration_indicator_o(sdi), .gate_refused_o(refused));
  stg_trig_src u_src (.core_clk_i(clk), .fire_i(fire), .fall_i(fall), .width_i(16'h32), .ext_trig_o(ext));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic complete_run;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Classic single cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic run(input int c);
    k = 0;
    repeat (c) begin
      @(posedge clk);
      if (done === 1'b1) k++;
    end
  endtask : run
  task automatic wdone;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1);
  endtask : wdone
  task automatic wmeas(input logic v);
    n = 0;
    while (meas !== v) begin
      @(posedge clk);
      n++;
    end
  endtask : wmeas
  task automatic pulse;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask : pulse
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (16) @(posedge clk);
    chk("outputs in reset", 32'h0, {swp, meas, done, halted, sdi, refused, ack});
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_CTRL);
    chk("ctrl", 32'h20, q);
    rd(OFS_AVG_COUNT);
    chk("avg", 32'h1, q);
    rd(OFS_USER_SWEEP);
    chk("user sweep", 32'h14, q);
    rd(8'h3c);
    chk("unmapped", 32'h0, q);
    wr(OFS_SPAN, 32'h3);
    rd(OFS_SWEEP_EFF);
    chk("coupled", 32'ha, q);
    wr(OFS_VIDEO, 32'h132);
    rd(OFS_SWEEP_EFF);
    chk("coupled narrow", 32'h28, q);
    wr(OFS_VIDEO, 32'h32);
    wr(OFS_USER_SWEEP, 32'h5);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_SWEEP_EFF);
    chk("manual", 32'h5, q);
    chk("override", 32'h1, sdi);
    wr(OFS_SPAN, 32'h0);
    rd(OFS_SWEEP_EFF);
    chk("zero span min", 32'h14, q);
    wr(OFS_USER_SWEEP, 32'h7270e00);
    rd(OFS_SWEEP_EFF);
    chk("zero span max", 32'h5f5e100, q);
    wr(OFS_USER_SWEEP, 32'h5);
    wr(OFS_SPAN, 32'h3);
    wdone();
    wdone();
    chk("free period", 32'h1, 32'(n >= 400 && n <= 610));
    wr(OFS_AVG_COUNT, 32'h2);
    wr(OFS_CTRL, 32'h1);
    while (halted !== 1'b1) @(posedge clk);
    wr(OFS_CTRL, 32'h8000_0001);
    run(3000);
    chk("single count", 32'h2, k);
    chk("halted", 32'h1, halted);
    chk("idle", 32'h0, swp);
    foreach (dq[i]) begin
      wr(OFS_TRIG_DELAY, dq[i][0]);
      rd(OFS_TRIG_DELAY);
      chk("trig delay", dq[i][1], q);
    end
    wr(OFS_TRIG_DELAY, 32'h3);
    for (int f = 0; f < 2; f++) begin
      fall <= f[0];
      // Let the new idle level pass the synchroniser before the edge select changes
      run(3);
      wr(OFS_CTRL, 32'h8000_0004 | 32'(f << 3));
      run(1000);
      chk("armed idle", 32'h0, meas);
      pulse();
      wmeas(1'b1);
      chk("ext delay", 32'h1, 32'(n >= 200 && n <= 310));
      wdone();
      wr(OFS_CTRL, 32'h0);
    end
    wr(OFS_TRIG_DELAY, 32'h0);
    wr(OFS_CTRL, 32'h8000_0002);
    run(1000);
    vid <= 7'h3c;
    run(300);
    chk("video at span", 32'h0, meas);
    vid <= 7'h28;
    wr(OFS_SPAN, 32'h0);
    chk("zero span", 32'h1, zs);
    vid <= 7'h32;
    run(300);
    chk("video equal", 32'h0, meas);
    vid <= 7'h33;
    wmeas(1'b1);
    chk("video start", 32'h1, 32'(n <= 110));
    wdone();
    wr(OFS_SPAN, 32'h3);
    wr(OFS_GATE_DELAY, 32'h2);
    wr(OFS_GATE_LENGTH, 32'h3);
    wr(OFS_CTRL, 32'h18);
    run(3);
    chk("gate free", 32'h1, refused);
    wr(OFS_CTRL, 32'h5c);
    run(3);
    chk("gate fft", 32'h1, refused);
    wr(OFS_CTRL, 32'h9c);
    run(3);
    chk("gate ok", 32'h0, refused);
    chk("edit span", 32'h10000, {zs, span});
    wr(OFS_CTRL, 32'h1c);
    run(1000);
    chk("restore span", 32'h3, {zs, span});
    pulse();
    wmeas(1'b1);
    chk("gate delay", 32'h1, 32'(n >= 100 && n <= 210));
    wmeas(1'b0);
    chk("gate length", 32'h1, 32'(n >= 200 && n <= 400));
    run(500);
    chk("paused", 32'h0, k + 32'(meas));
    pulse();
    wdone();
    chk("resumed", 32'h1, 32'(n >= 300 && n <= 410));
    complete_run();
  end
endmodule : stg_sequencer_tb
